// >>> common/mcst_consts.vh
// Constants for the module control and status timing block.
`ifndef MCST_CONSTS_VH
`define MCST_CONSTS_VH
// ----------------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------------
`define MCST_CLK_HZ 10000000
`define MCST_INIT_MS 2000
`define MCST_RST_MIN_US 2
`define MCST_INIT_W 25
`define MCST_RST_W 6
`define MCST_INIT_CYC 25'd20000000
`define MCST_RST_CYC 6'd20
// ----------------------------------------------------------------------------
// Two-wire slave
// ----------------------------------------------------------------------------
`define MCST_DEV_ADDR 7'h50
`define MCST_OFS_STATUS 8'h02
`define MCST_OFS_FLAGS 8'h03
`define MCST_OFS_MASK 8'h04
`define MCST_OFS_CTRL 8'h05
`define MCST_BITS_BYTE 4'h8
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define MCST_DNR_BIT 0
`define MCST_FLG_LOS 0
`define MCST_FLG_TXF 1
`define MCST_FLG_OTH 2
`define MCST_FLG_RDY 3
`define MCST_CTRL_PDOWN 0
`define MCST_MASK_RST 4'h0
`define MCST_FLAGS_RST 4'h0
`endif

// >>> rtl/mcst_top.v
// Control, status, interrupt and two-wire slave logic of a pluggable module.
`timescale 1ns/1ns
`include "mcst_consts.vh"

module mcst_top #(
  parameter [`MCST_INIT_W-1:0] INIT_CYC = `MCST_INIT_CYC
) (
  input wire clock_i,
  input wire nrst_i,
  input wire module_select_n_i,
  input wire module_reset_n_i,
  input wire low_power_request_i,
  input wire tx_disable_in_i,
  input wire scl_i,
  input wire sda_i,
  input wire rx_los_i,
  input wire tx_fault_i,
  input wire other_flag_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  output reg interrupt_out_n_o,
  output reg present_out_n_o,
  output reg low_power_o,
  output reg laser_off_o,
  output reg full_func_o
);

  // --------------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------------
  localparam [`MCST_RST_W-1:0] RST_CYC =
    `MCST_RST_CYC;

  // --------------------------------------------------------------------------
  // Slave states
  // --------------------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_AACK = 4'h2;
  localparam [3:0] S_OFS = 4'h3;
  localparam [3:0] S_OACK = 4'h4;
  localparam [3:0] S_WR = 4'h5;
  localparam [3:0] S_WACK = 4'h6;
  localparam [3:0] S_RD = 4'h7;
  localparam [3:0] S_RACK = 4'h8;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [5:0] sync1_ff;
  reg [5:0] sync2_ff;
  reg scl_d_ff;
  reg sda_d_ff;

  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_ff <= 6'h3f;
      sync2_ff <= 6'h3f;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= {module_select_n_i, module_reset_n_i, low_power_request_i,
                   tx_disable_in_i, scl_i, sda_i};
      sync2_ff <= sync1_ff;
      scl_d_ff <= sync2_ff[1];
      sda_d_ff <= sync2_ff[0];
    end
  end

  wire sel_n = sync2_ff[5];
  wire rst_pin_n = sync2_ff[4];
  wire lp_pin = sync2_ff[3];
  wire tx_disable_in_pin = sync2_ff[2];
  wire scl_s = sync2_ff[1];
  wire sda_s = sync2_ff[0];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
  wire stop_c = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

  // --------------------------------------------------------------------------
  // Reset pin qualification and initialisation
  // --------------------------------------------------------------------------
  reg [`MCST_RST_W-1:0] rst_cnt_ff;
  reg rst_hit_ff;
  reg [`MCST_INIT_W-1:0] init_cnt_ff;
  reg ready_ff;
  reg dnr_ff;

  // A pulse shorter than the minimum is a glitch and is ignored.
  wire rst_hold = rst_hit_ff & ~rst_pin_n;
  wire rst_release = rst_hit_ff & rst_pin_n;

  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_cnt_ff <= {`MCST_RST_W{1'b0}};
      rst_hit_ff <= 1'b0;
      init_cnt_ff <= {`MCST_INIT_W{1'b0}};
      ready_ff <= 1'b0;
      dnr_ff <= 1'b1;
    end
    else
    begin
      if (rst_pin_n)
        rst_cnt_ff <= {`MCST_RST_W{1'b0}};
      else if (rst_cnt_ff != RST_CYC)
        rst_cnt_ff <= rst_cnt_ff + 1'b1;
      if (!rst_pin_n && rst_cnt_ff == RST_CYC)
        rst_hit_ff <= 1'b1;
      else if (rst_pin_n)
        rst_hit_ff <= 1'b0;
      if (rst_hold || rst_release)
      begin
        init_cnt_ff <= {`MCST_INIT_W{1'b0}};
        ready_ff <= 1'b0;
        dnr_ff <= 1'b1;
      end
      else if (!ready_ff)
      begin
        if (init_cnt_ff == INIT_CYC - 1'b1)
        begin
          ready_ff <= 1'b1;
          dnr_ff <= 1'b0;
        end
        else
          init_cnt_ff <= init_cnt_ff + 1'b1;
      end
    end
  end

  wire ready_rise = ~ready_ff & ~rst_hold & ~rst_release & (init_cnt_ff == INIT_CYC - 1'b1);

  // --------------------------------------------------------------------------
  // Two-wire slave
  // --------------------------------------------------------------------------
  reg [3:0] st_ff;
  reg [3:0] nxt_st;
  reg [3:0] bit_cnt_ff;
  reg [7:0] sr_ff;
  reg [7:0] ptr_ff;
  reg rw_ff;
  reg nack_ff;
  reg stop_seen_ff;
  reg rd_flags_ff;
  reg [3:0] pend_mask_ff;
  reg pend_mask_v_ff;
  reg pend_pd_ff;
  reg pend_pd_v_ff;
  reg [3:0] flags_ff;
  reg [3:0] mask_ff;
  reg pdown_ff;
  reg [7:0] rd_byte;

  // Slave answers only when initialised and selected.
  wire slave_on = ready_ff & ~sel_n & ~rst_hold;
  wire end_evt = stop_seen_ff & scl_fall;

  always @*
  begin
    case (ptr_ff)
      `MCST_OFS_STATUS: rd_byte = {7'h00, dnr_ff};
      `MCST_OFS_FLAGS: rd_byte = {4'h0, flags_ff};
      `MCST_OFS_MASK: rd_byte = {4'h0, mask_ff};
      `MCST_OFS_CTRL: rd_byte = {7'h00, pdown_ff};
      default: rd_byte = 8'h00;
    endcase
  end

  always @*
  begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: nxt_st = S_IDLE;
      S_ADDR:
        if (scl_fall && bit_cnt_ff == `MCST_BITS_BYTE)
          nxt_st = (sr_ff[7:1] == `MCST_DEV_ADDR) ? S_AACK : S_IDLE;
      S_AACK:
        if (scl_fall)
          nxt_st = rw_ff ? S_RD : S_OFS;
      S_OFS:
        if (scl_fall && bit_cnt_ff == `MCST_BITS_BYTE)
          nxt_st = S_OACK;
      S_OACK:
        if (scl_fall)
          nxt_st = S_WR;
      S_WR:
        if (scl_fall && bit_cnt_ff == `MCST_BITS_BYTE)
          nxt_st = S_WACK;
      S_WACK:
        if (scl_fall)
          nxt_st = S_WR;
      S_RD:
        if (scl_fall && bit_cnt_ff == `MCST_BITS_BYTE)
          nxt_st = S_RACK;
      S_RACK:
        if (scl_fall)
          nxt_st = nack_ff ? S_IDLE : S_RD;
      default: nxt_st = S_IDLE;
    endcase
    if (start_c)
      nxt_st = S_ADDR;
    if (stop_c || !slave_on)
      nxt_st = S_IDLE;
  end

  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_ff <= S_IDLE;
      bit_cnt_ff <= 4'h0;
      sr_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      if (nxt_st != st_ff || start_c)
        bit_cnt_ff <= 4'h0;
      else if (scl_rise)
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      if (scl_rise)
        sr_ff <= {sr_ff[6:0], sda_s};
      if (scl_rise && st_ff == S_RACK)
        nack_ff <= sda_s;
      if (st_ff == S_ADDR && nxt_st == S_AACK)
        rw_ff <= sr_ff[0];
      if (st_ff == S_OFS && nxt_st == S_OACK)
        ptr_ff <= sr_ff;
      if ((st_ff == S_WACK && nxt_st == S_WR) || (st_ff == S_RD && nxt_st == S_RACK))
        ptr_ff <= ptr_ff + 1'b1;
      // Data and acknowledge change on a falling clock; a start, stop, deselect or reset hold releases the line at once.
      if (nxt_st == S_AACK || nxt_st == S_OACK || nxt_st == S_WACK)
        sda_oe_n_o <= 1'b0;
      else if (nxt_st == S_RD && scl_fall)
        sda_oe_n_o <= (st_ff == S_RD) ? rd_byte[3'h7 - bit_cnt_ff[2:0]] : rd_byte[7];
      else if (nxt_st != S_RD)
        sda_oe_n_o <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Writes, flags and masks, committed at the end of a transaction
  // --------------------------------------------------------------------------
  wire [3:0] cond = {ready_rise, other_flag_i, tx_fault_i, rx_los_i};

  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stop_seen_ff <= 1'b0;
      rd_flags_ff <= 1'b0;
      pend_mask_ff <= `MCST_MASK_RST;
      pend_mask_v_ff <= 1'b0;
      pend_pd_ff <= 1'b0;
      pend_pd_v_ff <= 1'b0;
      flags_ff <= `MCST_FLAGS_RST;
      mask_ff <= `MCST_MASK_RST;
      pdown_ff <= 1'b0;
    end
    else
    begin
      if (end_evt || start_c)
        stop_seen_ff <= 1'b0;
      else if (stop_c)
        stop_seen_ff <= 1'b1;
      if (end_evt || rst_hold)
        rd_flags_ff <= 1'b0;
      else if (st_ff == S_RD && nxt_st == S_RACK && ptr_ff == `MCST_OFS_FLAGS)
        rd_flags_ff <= 1'b1;
      if (st_ff == S_WR && nxt_st == S_WACK)
      begin
        if (ptr_ff == `MCST_OFS_MASK)
        begin
          pend_mask_ff <= sr_ff[3:0];
          pend_mask_v_ff <= 1'b1;
        end
        if (ptr_ff == `MCST_OFS_CTRL)
        begin
          pend_pd_ff <= sr_ff[`MCST_CTRL_PDOWN];
          pend_pd_v_ff <= 1'b1;
        end
      end
      else if (end_evt)
      begin
        pend_mask_v_ff <= 1'b0;
        pend_pd_v_ff <= 1'b0;
      end
      if (rst_hold)
      begin
        flags_ff <= `MCST_FLAGS_RST;
        mask_ff <= `MCST_MASK_RST;
        pdown_ff <= 1'b0;
      end
      else
      begin
        // A condition present in the clearing cycle keeps its flag set.
        flags_ff <= (flags_ff & ~{4{end_evt & rd_flags_ff}}) | cond;
        if (end_evt && pend_mask_v_ff)
          mask_ff <= pend_mask_ff;
        if (end_evt && pend_pd_v_ff)
          pdown_ff <= pend_pd_ff;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      interrupt_out_n_o <= 1'b1;
      present_out_n_o <= 1'b0;
      low_power_o <= 1'b0;
      laser_off_o <= 1'b1;
      full_func_o <= 1'b0;
    end
    else
    begin
      interrupt_out_n_o <= ~|(flags_ff & ~mask_ff);
      present_out_n_o <= 1'b0;
      low_power_o <= lp_pin | pdown_ff;
      laser_off_o <= tx_disable_in_pin;
      full_func_o <= ready_ff & flags_ff[`MCST_FLG_RDY] | full_func_o & ready_ff;
    end
  end

endmodule // mcst_top

// >>> tb/mcst_sva.sv
// Assertion checker for the module control and status block.
`timescale 1ns/1ns
`include "mcst_consts.vh"
module mcst_sva #(
  parameter [`MCST_INIT_W-1:0] INIT_CYC = 25'd50
) (
  input wire clock_i,
  input wire nrst_i,
  input wire module_select_n_i,
  input wire module_reset_n_i,
  input wire low_power_request_i,
  input wire tx_disable_in_i,
  input wire sda_oe_n_o,
  input wire interrupt_out_n_o,
  input wire present_out_n_o,
  input wire low_power_o,
  input wire laser_off_o,
  input wire full_func_o
);
  // --------------------
  // Start-up counter
  // --------------------
  reg [31:0] cnt_ff;
  reg [5:0] lo_ff;
  reg prev_ff;
  // Only a long pin reset restarts the count, because short pulses are ignored.
  always @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= 32'h0;
      lo_ff <= 6'h0;
      prev_ff <= 1'b1;
    end
    else
    begin
      prev_ff <= module_reset_n_i;
      lo_ff <= module_reset_n_i ? 6'h0 : (lo_ff == 6'h3f ? lo_ff : lo_ff + 6'h1);
      if (module_reset_n_i && !prev_ff && lo_ff >= 6'd25)
        cnt_ff <= 32'h0;
      else if (cnt_ff != 32'hffffffff)
        cnt_ff <= cnt_ff + 32'h1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_present; present_out_n_o == 1'b0; endproperty
  a_present: assert property (p_present)
    else $error("present output not low");
  property p_laser_off; $rose(tx_disable_in_i) |-> ##[1:4] laser_off_o; endproperty
  a_laser_off: assert property (p_laser_off)
    else $error("laser not disabled");
  property p_laser_on; $fell(tx_disable_in_i) |-> ##[1:4] !laser_off_o; endproperty
  a_laser_on: assert property (p_laser_on)
    else $error("laser not enabled");
  property p_lowpow; $rose(low_power_request_i) |-> ##[1:4] low_power_o; endproperty
  a_lowpow: assert property (p_lowpow)
    else $error("low power not entered");
  property p_ready; $rose(full_func_o) |-> !interrupt_out_n_o; endproperty
  a_ready: assert property (p_ready)
    else $error("functional without interrupt");
  property p_init; (cnt_ff == INIT_CYC + 8) |-> full_func_o && !interrupt_out_n_o; endproperty
  a_init: assert property (p_init)
    else $error("start-up not complete in time");
  property p_quiet; !full_func_o |-> sda_oe_n_o; endproperty
  a_quiet: assert property (p_quiet)
    else $error("data line driven before ready");
  property p_desel; module_select_n_i [*4] |-> sda_oe_n_o; endproperty
  a_desel: assert property (p_desel)
    else $error("data line driven while deselected");
  c_int_on: cover property ($fell(interrupt_out_n_o));
  c_int_off: cover property ($rose(interrupt_out_n_o));
  c_ack: cover property (!sda_oe_n_o);
endmodule // mcst_sva
bind mcst_top mcst_sva #(.INIT_CYC(INIT_CYC)) u_sva (.clock_i(clock_i), .nrst_i(nrst_i),
  .module_select_n_i(module_select_n_i), .module_reset_n_i(module_reset_n_i),
  .low_power_request_i(low_power_request_i), .tx_disable_in_i(tx_disable_in_i),
  .sda_oe_n_o(sda_oe_n_o), .interrupt_out_n_o(interrupt_out_n_o),
  .present_out_n_o(present_out_n_o), .low_power_o(low_power_o),
  .laser_off_o(laser_off_o), .full_func_o(full_func_o));

// >>> tb/mcst_host.sv
// Two-wire host controller model for the management bus.
`timescale 1ns/1ns
`include "mcst_consts.vh"
module mcst_host (
  input wire clock_i,
  input wire sda_i,
  output reg scl_o = 1'b1,
  output reg sda_dn_o = 1'b0,
  output reg rd_v_o = 1'b0,
  output reg [7:0] rd_d_o = 8'h00
);
  // --------------------
  // Bus cycles
  // --------------------
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clock_i);
  end
  endtask
  // One bit per 8 clocks gives the 800 ns serial clock period.
  task bt(input b, output r);
  begin
    sda_dn_o <= ~b;
    cyc(2);
    scl_o <= 1'b1;
    cyc(2);
    r = sda_i;
    cyc(2);
    scl_o <= 1'b0;
    cyc(2);
  end
  endtask
  task by(input [7:0] d, output [7:0] r);
    integer i;
    reg x;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bt(d[i], x);
      r[i] = x;
    end
    bt(1'b1, x);
  end
  endtask
  task start;
  begin
    sda_dn_o <= 1'b1;
    cyc(4);
    scl_o <= 1'b0;
    cyc(2);
  end
  endtask
  // The clock falls once after the stop so that deferred effects take hold.
  task stop;
  begin
    sda_dn_o <= 1'b1;
    cyc(2);
    scl_o <= 1'b1;
    cyc(4);
    sda_dn_o <= 1'b0;
    cyc(4);
    scl_o <= 1'b0;
    cyc(4);
    scl_o <= 1'b1;
    cyc(4);
  end
  endtask
  task xfer(input [7:0] ofs, input wr, input [7:0] wd);
    reg [7:0] r;
  begin
    start;
    by({`MCST_DEV_ADDR, 1'b0}, r);
    by(ofs, r);
    if (wr)
      by(wd, r);
    stop;
    if (!wr)
    begin
      start;
      by({`MCST_DEV_ADDR, 1'b1}, r);
      by(8'hff, r);
      stop;
      rd_d_o <= r;
      rd_v_o <= 1'b1;
      cyc(1);
      rd_v_o <= 1'b0;
    end
  end
  endtask
endmodule // mcst_host

// >>> tb/tb_top.sv
// Self-checking bench for the module control and status block.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam [24:0] INIT = 25'd50;
  reg clock_i = 1'b0;
  reg nrst_i = 1'b0;
  reg sel_n = 1'b0;
  reg mrst_n = 1'b1;
  reg lpr = 1'b0;
  reg txd = 1'b1;
  reg [2:0] cond = 3'h0;
  reg pin_v = 1'b0;
  reg [7:0] pin_d = 8'h00;
  reg [7:0] e;
  reg [7:0] q[$];
  integer n_fail = 0;
  integer comparisons = 0;
  integer k;
  wire scl, sda_dn, rd_v, sda_o, sda_oe_n, int_n, prs_n, lp, lo, ff;
  wire [7:0] rd_d;
  wire sda_w = ~(sda_dn | (~sda_oe_n & ~sda_o));
  mcst_top #(.INIT_CYC(INIT)) i_dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .module_select_n_i(sel_n), .module_reset_n_i(mrst_n), .low_power_request_i(lpr),
    .tx_disable_in_i(txd), .scl_i(scl), .sda_i(sda_w), .rx_los_i(cond[0]),
    .tx_fault_i(cond[1]), .other_flag_i(cond[2]), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .interrupt_out_n_o(int_n), .present_out_n_o(prs_n), .low_power_o(lp),
    .laser_off_o(lo), .full_func_o(ff));
  mcst_host i_host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_dn_o(sda_dn),
    .rd_v_o(rd_v), .rd_d_o(rd_d));
  // --------------------
  // Tasks
  // --------------------
  task w(input integer n);
  begin
    repeat (n) @(posedge clock_i);
  end
  endtask
  task pins(input [7:0] x);
  begin
    w(5);
    q.push_back(x);
    pin_d <= {3'h0, int_n, prs_n, lp, lo, ff};
    pin_v <= 1'b1;
    w(1);
    pin_v <= 1'b0;
  end
  endtask
  task rd(input [7:0] ofs, input [7:0] x);
  begin
    q.push_back(x);
    i_host.xfer(ofs, 1'b0, 8'h00);
  end
  endtask
  task tend(input [8*8-1:0] s);
  begin
    $display("test %0s done", s);
  end
  endtask
  task stop_test;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // --------------------
  // Clock, watcher, sequence
  // --------------------
  initial
  begin
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    if (rd_v || pin_v)
    begin
      e = q.pop_front();
      if (rd_v)
        `CHK("read byte", e, rd_d)
      else
        `CHK("pins", e, pin_d)
    end
  end
  initial
  begin
    #2000000;
    n_fail++;
    stop_test;
  end
  initial
  begin
    void'($urandom(32'h5e2e));
    w(10);
    nrst_i <= 1'b1;
    w(INIT + 10);
    pins(8'h03);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h08);
    pins(8'h13);
    tend("init");
    for (k = 0; k < 3; k = k + 1)
    begin
      cond <= 3'h1 << k;
      w(5);
      cond <= 3'h0;
      pins(8'h03);
      rd(8'h03, 8'h01 << k);
      pins(8'h13);
    end
    tend("flags");
    k = $urandom % 3;
    i_host.xfer(8'h04, 1'b1, 8'h0f);
    cond <= 3'h1 << k;
    w(5);
    cond <= 3'h0;
    pins(8'h13);
    i_host.xfer(8'h04, 1'b1, 8'h00);
    pins(8'h03);
    rd(8'h03, 8'h01 << k);
    pins(8'h13);
    tend("mask");
    i_host.xfer(8'h05, 1'b1, 8'h01);
    pins(8'h17);
    i_host.xfer(8'h05, 1'b1, 8'h00);
    pins(8'h13);
    lpr <= 1'b1;
    pins(8'h17);
    lpr <= 1'b0;
    txd <= 1'b0;
    pins(8'h11);
    txd <= 1'b1;
    tend("power");
    sel_n <= 1'b1;
    w(5);
    rd(8'h02, 8'hff);
    sel_n <= 1'b0;
    w(5);
    rd(8'h06, 8'h00);
    tend("select");
    // A pulse below the minimum must leave the module fully functional.
    mrst_n <= 1'b0;
    w(10);
    mrst_n <= 1'b1;
    pins(8'h13);
    mrst_n <= 1'b0;
    w(30);
    mrst_n <= 1'b1;
    pins(8'h12);
    w(INIT + 10);
    pins(8'h03);
    tend("reset");
    w(2);
    stop_test;
  end
endmodule // tb_top
